// ### rtl/bst_tap.sv
// Purpose: test access port with instruction, bypass, id and boundary registers
// Assumes: i_core_clk at least eight times the tck rate; tap pins asynchronous
// Notes: tck edges are found by sampling, so tdo lags the falling edge slightly
// What this block does
// - sixteen-state controller steps on each tck rise using sampled tms
// - system reset acts as power-on reset forcing test-logic-reset
// - five-bit instruction register picks the data register between tdi and tdo
// - every unassigned instruction code acts as bypass
// - extest selects boundary chain, drives pins from it, captures pins
// - sample selects boundary chain, captures pins, preload, pins stay normal
// - highz floats all chain outputs and selects bypass
// - clamp drives pins from boundary chain while bypass is shifted
// - idcode selects the 32-bit identification register
// - bypass is a single stage from tdi to tdo
// - id holds version, part number, maker code, and constant one in bit 0
// - chain covers signal pins only, never supply or test pins
// - chain uses input, tristate output, control and internal cells
// - boundary cells are test-only; in normal operation the outputs reach the pins one core cycle late
// - sample and extest capture pins and drivers in parallel on tck rise
`timescale 1ns/1ps
module bst_tap #(
    parameter logic [3:0] ID_VERSION = 4'h1,      // arbitrary value
    parameter logic [15:0] ID_PART = 16'hA5C3,    // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2AA     // arbitrary value
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire bst_pkg::bst_jtag_in_t i_jtag,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic [bst_pkg::N_OUT-1:0] i_sys_out,
    input wire logic [bst_pkg::N_OUT-1:0] i_sys_oe,
    input wire logic [bst_pkg::N_IN-1:0] i_pin_in,
    output logic [bst_pkg::N_OUT-1:0] o_pin_out,
    output logic [bst_pkg::N_OUT-1:0] o_pin_oe
);
    import bst_pkg::*;

    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_BIT};

    bst_jtag_in_t sync1_q, sync2_q;
    logic tck_prev_q;
    logic [N_IN-1:0] pin1_q, pin2_q;
    bst_tap_state_t state_q;
    logic [IR_W-1:0] ir_sh_q, ir_q;
    logic bypass_q, scan_q, selftest_q;
    logic [ID_W-1:0] id_sh_q;
    logic [BSR_LEN-1:0] bsr_sh_q, bsr_upd_q, bsr_cap;
    logic tck_rise, tck_fall, tap_rst, tms, tdi, dr_lsb;
    bst_dr_sel_t dr_sel;

    // tck, tms, tdi, test reset and pins all pass two flops first
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync1_q <= JTAG_IDLE;
            sync2_q <= JTAG_IDLE;
            tck_prev_q <= 1'b0;
        end else begin
            sync1_q <= i_jtag;
            sync2_q <= sync1_q;
            tck_prev_q <= sync2_q.tck;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin1_q <= '0;
            pin2_q <= '0;
        end else begin
            pin1_q <= i_pin_in;
            pin2_q <= pin1_q;
        end
    end

    assign tck_rise = sync2_q.tck & ~tck_prev_q;
    assign tck_fall = ~sync2_q.tck & tck_prev_q;
    assign tms = sync2_q.tms;
    assign tdi = sync2_q.tdi;
    assign tap_rst = i_sys_rst | ~sync2_q.trst_n;

    function automatic bst_tap_state_t tap_next(input bst_tap_state_t s, input logic m);
        case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction

    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            state_q <= TAP_RESET;
        end else if (tck_rise) begin
            state_q <= tap_next(state_q, tms);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (tck_rise && state_q == TAP_CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (tck_rise && state_q == TAP_SHIFT_IR) begin
            ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (tap_rst || state_q == TAP_RESET) begin
            ir_q <= IR_IDCODE;
        end else if (tck_rise && state_q == TAP_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // decode; highz and clamp shift through bypass, unknown codes fall to bypass
    always_comb begin
        case (ir_q)
            IR_EXTEST, IR_SAMPLE: dr_sel = DR_BSR;
            IR_IDCODE: dr_sel = DR_ID;
            IR_INT_SCAN: dr_sel = DR_SCAN;
            IR_MEMORY_SELFTEST: dr_sel = DR_SELFTEST;
            default: dr_sel = DR_BYPASS;
        endcase
    end

    // internal cells see core nodes outside this block, so they capture zero
    always_comb begin
        bsr_cap = '0;
        for (int k = 0; k < N_OUT; k++) begin
            bsr_cap[OUT_CELL[k]] = i_sys_out[k];
            bsr_cap[CTL_CELL[k]] = i_sys_oe[k];
        end
        for (int k = 0; k < N_IN; k++) begin
            bsr_cap[IN_CELL[k]] = pin2_q[k];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            bypass_q <= 1'b0;
            scan_q <= 1'b0;
            selftest_q <= 1'b0;
        end else if (tck_rise && state_q == TAP_CAP_DR) begin
            bypass_q <= 1'b0;
            scan_q <= 1'b0;
            selftest_q <= 1'b0;
        end else if (tck_rise && state_q == TAP_SHIFT_DR) begin
            if (dr_sel == DR_BYPASS) bypass_q <= tdi;
            if (dr_sel == DR_SCAN) scan_q <= tdi;
            if (dr_sel == DR_SELFTEST) selftest_q <= tdi;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            id_sh_q <= ID_VALUE;
        end else if (tck_rise && state_q == TAP_CAP_DR && dr_sel == DR_ID) begin
            id_sh_q <= ID_VALUE;
        end else if (tck_rise && state_q == TAP_SHIFT_DR && dr_sel == DR_ID) begin
            id_sh_q <= {tdi, id_sh_q[ID_W-1:1]};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            bsr_sh_q <= '0;
        end else if (tck_rise && state_q == TAP_CAP_DR && dr_sel == DR_BSR) begin
            bsr_sh_q <= bsr_cap;
        end else if (tck_rise && state_q == TAP_SHIFT_DR && dr_sel == DR_BSR) begin
            bsr_sh_q <= {tdi, bsr_sh_q[BSR_LEN-1:1]};
        end
    end

    // preload under sample lands here without touching the pins
    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            bsr_upd_q <= '0;
        end else if (tck_rise && state_q == TAP_UPD_DR && dr_sel == DR_BSR) begin
            bsr_upd_q <= bsr_sh_q;
        end
    end

    // one core cycle of latency on pins, traded for flop-driven outputs
    for (genvar k = 0; k < N_OUT; k++) begin : g_pin
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
                o_pin_out[k] <= 1'b0;
                o_pin_oe[k] <= 1'b0;
            end else begin
                case (ir_q)
                    IR_EXTEST, IR_CLAMP: begin
                        o_pin_out[k] <= bsr_upd_q[OUT_CELL[k]];
                        o_pin_oe[k] <= bsr_upd_q[CTL_CELL[k]];
                    end
                    IR_HIGHZ: begin
                        o_pin_out[k] <= i_sys_out[k];
                        o_pin_oe[k] <= 1'b0;
                    end
                    default: begin
                        o_pin_out[k] <= i_sys_out[k];
                        o_pin_oe[k] <= i_sys_oe[k];
                    end
                endcase
            end
        end
    end

    always_comb begin
        case (dr_sel)
            DR_BSR: dr_lsb = bsr_sh_q[0];
            DR_ID: dr_lsb = id_sh_q[0];
            DR_SCAN: dr_lsb = scan_q;
            DR_SELFTEST: dr_lsb = selftest_q;
            default: dr_lsb = bypass_q;
        endcase
    end

    // tdo changes on the falling edge so the tester samples it stable
    always_ff @(posedge i_core_clk) begin
        if (tap_rst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= (state_q == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_lsb;
            o_tdo_oe <= (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);
        end
    end

    sequence s_rise_in(bst_tap_state_t st);
        tck_rise && state_q == st;
    endsequence

    property p_trst_reset;
        @(posedge i_core_clk) !sync2_q.trst_n |=> state_q == TAP_RESET && ir_q == IR_IDCODE;
    endproperty
    a_trst_reset: assert property (p_trst_reset) else $error("test reset ignored");

    property p_por_reset;
        @(posedge i_core_clk) i_sys_rst |=> state_q == TAP_RESET ##1 ir_q == IR_IDCODE;
    endproperty
    a_por_reset: assert property (p_por_reset) else $error("power-on reset ignored");

    property p_leave_reset;
        @(posedge i_core_clk) disable iff (tap_rst)
            s_rise_in(TAP_RESET) ##0 !tms |=> state_q == TAP_IDLE;
    endproperty
    a_leave_reset: assert property (p_leave_reset) else $error("bad step from reset");

    property p_unknown_bypass;
        @(posedge i_core_clk) disable iff (tap_rst)
            ir_q == 5'h1E || ir_q == 5'h03 || ir_q == IR_HIGHZ |-> dr_sel == DR_BYPASS;
    endproperty
    a_unknown_bypass: assert property (p_unknown_bypass) else $error("bad bypass decode");

    property p_highz;
        @(posedge i_core_clk) disable iff (i_sys_rst) ir_q == IR_HIGHZ |=> o_pin_oe == '0;
    endproperty
    a_highz: assert property (p_highz) else $error("pin driven in highz");

    property p_extest_drive;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            ir_q == IR_EXTEST |=> o_pin_out[0] == $past(bsr_upd_q[OUT_CELL[0]])
                && o_pin_oe[0] == $past(bsr_upd_q[CTL_CELL[0]]);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("extest pin mismatch");

    property p_sample_normal;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            ir_q == IR_SAMPLE |=> o_pin_out == $past(i_sys_out) && o_pin_oe == $past(i_sys_oe);
    endproperty
    a_sample_normal: assert property (p_sample_normal) else $error("sample disturbed pins");

    property p_id_capture;
        @(posedge i_core_clk) disable iff (tap_rst)
            s_rise_in(TAP_CAP_DR) ##0 dr_sel == DR_ID |=> id_sh_q == ID_VALUE && id_sh_q[0];
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id capture wrong");

    property p_bypass_shift;
        @(posedge i_core_clk) disable iff (tap_rst)
            s_rise_in(TAP_SHIFT_DR) ##0 dr_sel == DR_BYPASS |=> bypass_q == $past(tdi);
    endproperty
    a_bypass_shift: assert property (p_bypass_shift) else $error("bypass stage wrong");

    property p_pin_capture;
        @(posedge i_core_clk) disable iff (tap_rst)
            s_rise_in(TAP_CAP_DR) ##0 dr_sel == DR_BSR
                |=> bsr_sh_q[IN_CELL[0]] == $past(pin2_q[0])
                && bsr_sh_q[OUT_CELL[1]] == $past(i_sys_out[1]);
    endproperty
    a_pin_capture: assert property (p_pin_capture) else $error("chain capture wrong");
endmodule

// ### rtl/bst_pkg.sv
// Purpose: shared constants and types of the boundary scan test access port
// Assumes: tap pins are sampled by the core clock, which is much faster than tck
// Notes: identification field values are top-level parameters
package bst_pkg;
    localparam int IR_W = 5;
    localparam int ID_W = 32;
    localparam int BSR_LEN = 42;
    localparam int N_OUT = 3;
    localparam int N_IN = 3;

    localparam logic [IR_W-1:0] IR_EXTEST = 5'h00;
    localparam logic [IR_W-1:0] IR_SAMPLE = 5'h01;
    localparam logic [IR_W-1:0] IR_INT_SCAN = 5'h02;
    localparam logic [IR_W-1:0] IR_CLAMP = 5'h04;
    localparam logic [IR_W-1:0] IR_HIGHZ = 5'h05;
    localparam logic [IR_W-1:0] IR_MEMORY_SELFTEST = 5'h0A;
    localparam logic [IR_W-1:0] IR_IDCODE = 5'h0C;
    localparam logic [IR_W-1:0] IR_BYPASS = 5'h1F;
    // fixed pattern loaded when capturing the instruction register
    localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;

    // identification field positions
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam logic ID_FIXED_BIT = 1'b1;

    // chain positions: three tristate_output_cell pins with their control cells,
    // three input cells; every other position is an internal cell
    localparam int OUT_CELL [N_OUT] = '{8, 12, 31};
    localparam int CTL_CELL [N_OUT] = '{9, 13, 32};
    localparam int IN_CELL [N_IN] = '{16, 18, 35};

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2,
        TAP_SHIFT_DR = 4'h6,
        TAP_EXIT1_DR = 4'h7,
        TAP_PAUSE_DR = 4'h5,
        TAP_EXIT2_DR = 4'h4,
        TAP_UPD_DR = 4'hC,
        TAP_SEL_IR = 4'hD,
        TAP_CAP_IR = 4'hF,
        TAP_SHIFT_IR = 4'hE,
        TAP_EXIT1_IR = 4'hA,
        TAP_PAUSE_IR = 4'hB,
        TAP_EXIT2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } bst_tap_state_t;

    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0,
        DR_BSR = 3'h1,
        DR_ID = 3'h2,
        DR_SCAN = 3'h3,
        DR_SELFTEST = 3'h4
    } bst_dr_sel_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bst_jtag_in_t;

    localparam bst_jtag_in_t JTAG_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
endpackage

// ### tb/bst_tester.sv
// Purpose: boundary-scan tester model driving the tap pins
// Assumes: tck period of eight core cycles, low five, high three
// Notes: tdo is read just before each tck rise, well after the fall update
`timescale 1ns/1ps
module bst_tester (
    input wire logic i_core_clk,
    input wire logic i_tdo,
    input wire logic i_tdo_oe,
    output bst_pkg::bst_jtag_in_t o_jtag
);
    import bst_pkg::*;
    initial o_jtag = JTAG_IDLE;
    // tck stands high between frames; tms and tdi move only while tck is low
    task step(input logic tms, input logic tdi, output logic tdo);
        @(negedge i_core_clk);
        o_jtag.tck = 1'b0;
        o_jtag.tms = tms;
        o_jtag.tdi = tdi;
        repeat (5) @(negedge i_core_clk);
        // released tdo reads inverted, so a missing enable corrupts the data
        tdo = i_tdo_oe ? i_tdo : ~i_tdo;
        o_jtag.tck = 1'b1;
        repeat (2) @(negedge i_core_clk);
    endtask
    // leading tms 0 parks in idle from reset or idle; lsb shifted first
    task shift(input logic ir, input int n, input logic [63:0] din,
               output logic [63:0] dout);
        logic b;
        int i;
        dout = '0;
        step(1'b0, 1'b1, b);
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        // the last rise is seen late by the core; let it reach ir and pins
        repeat (3) @(negedge i_core_clk);
    endtask
    task test_reset();
        @(negedge i_core_clk);
        o_jtag.trst_n = 1'b0;
        repeat (16) @(negedge i_core_clk);
        o_jtag.trst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
    endtask
endmodule

// ### tb/test_bst_tap.sv
// Purpose: self-checking bench of the test access port
// Assumes: tester model owns the tap pins, bench owns the system pins
// Notes: register lengths are found by shifting a 64-bit pattern through
`timescale 1ns/1ps
module test_bst_tap;
    import bst_pkg::*;
    localparam logic [3:0] VER = 4'h6; // arbitrary value
    localparam logic [15:0] PART = 16'h3C5A; // arbitrary value
    localparam logic [10:0] MAKER = 11'h155; // arbitrary value
    localparam logic [31:0] ID = {VER, PART, MAKER, ID_FIXED_BIT};
    localparam logic [63:0] PAT = 64'hC3A5_96F0_1E2D_B487;
    logic core_clk;
    logic sys_rst;
    bst_jtag_in_t jtag;
    logic tdo;
    logic tdo_oe;
    logic [N_OUT-1:0] sys_out;
    logic [N_OUT-1:0] sys_oe;
    logic [N_IN-1:0] pin_in;
    logic [N_OUT-1:0] pin_out;
    logic [N_OUT-1:0] pin_oe;
    logic [63:0] got;
    logic [63:0] pre;
    logic [63:0] want;
    int bad_count;
    int comparisons;
    int cycles;
    logic [4:0] codes [11] = '{IR_BYPASS, IR_HIGHZ, IR_CLAMP, IR_INT_SCAN,
        IR_MEMORY_SELFTEST, 5'h03, 5'h11, 5'h1E, IR_IDCODE, IR_SAMPLE, IR_EXTEST};
    int lens [11] = '{1, 1, 1, 1, 1, 1, 1, 1, 32, 42, 42};

    bst_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) i_bst_tap (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_jtag(jtag),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_sys_out(sys_out), .i_sys_oe(sys_oe),
        .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe));
    bst_tester i_bst_tester (.i_core_clk(core_clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe),
        .o_jtag(jtag));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // whole run is near 9200 core cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            end_of_test();
        end
    end

    task check(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task pins(input logic [2:0] o, input logic [2:0] e);
        check({58'h0, pin_oe, pin_out}, {58'h0, e, o});
    endtask
    task load_ir(input logic [4:0] c);
        i_bst_tester.shift(1'b1, IR_W, {59'h0, c}, got);
        check({59'h0, got[4:0]}, {59'h0, IR_CAPTURE});
    endtask
    function automatic logic [63:0] chain(input logic [2:0] o, c, p);
        logic [63:0] r;
        r = '0;
        for (int k = 0; k < 3; k++) begin
            r[OUT_CELL[k]] = o[k];
            r[CTL_CELL[k]] = c[k];
            r[IN_CELL[k]] = p[k];
        end
        return r;
    endfunction

    initial begin
        sys_rst = 1'b1;
        sys_out = 3'b010;
        sys_oe = 3'b110;
        pin_in = 3'b101;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge core_clk);
        pins(sys_out, sys_oe);
        i_bst_tester.shift(1'b0, ID_W, 64'h0, got);
        check({32'h0, got[31:0]}, {32'h0, ID});
        $display("test power-on id done");
        for (int j = 0; j < 11; j++) begin
            load_ir(codes[j]);
            i_bst_tester.shift(1'b0, 64, PAT, got);
            want = PAT & ((64'h1 << (64 - lens[j])) - 64'h1);
            check(got >> lens[j], want);
            want = (lens[j] == 32) ? {32'h0, ID} : 64'h0;
            got = got & ((64'h1 << lens[j]) - 64'h1);
            if (lens[j] != 42) check(got, want);
        end
        $display("test register lengths done");
        load_ir(IR_SAMPLE);
        pins(sys_out, sys_oe);
        pre = chain(3'b101, 3'b011, 3'b000);
        i_bst_tester.shift(1'b0, BSR_LEN, pre, got);
        check(got, chain(sys_out, sys_oe, pin_in));
        pins(sys_out, sys_oe);
        $display("test sample and preload done");
        load_ir(IR_EXTEST);
        pins(3'b101, 3'b011);
        pin_in = 3'b010;
        repeat (4) @(negedge core_clk);
        i_bst_tester.shift(1'b0, BSR_LEN, pre, got);
        want = chain(3'h0, 3'h0, 3'h2);
        check(got & chain(3'h0, 3'h0, 3'h7), want);
        pins(3'b101, 3'b011);
        $display("test extest done");
        load_ir(IR_CLAMP);
        pins(3'b101, 3'b011);
        load_ir(IR_HIGHZ);
        check({61'h0, pin_oe}, 64'h0);
        load_ir(IR_BYPASS);
        pins(sys_out, sys_oe);
        $display("test clamp highz bypass done");
        i_bst_tester.test_reset();
        check({63'h0, tdo_oe}, 64'h0);
        i_bst_tester.shift(1'b0, ID_W, 64'h0, got);
        check({32'h0, got[31:0]}, {32'h0, ID});
        $display("test test reset done");
        end_of_test();
    end
endmodule
